// [spi_status_pkg.sv]
package spi_status_pkg;

  // bit positions of the status word
  localparam int BitIntReadErr   = 29;
  localparam int BitIntWriteErr  = 28;
  localparam int BitErrLogEntry  = 27;
  localparam int BitRdUnderflow  = 26;
  localparam int BitRdEmpty      = 25;
  localparam int BitWrOverflow   = 24;
  localparam int BitFraming      = 21;
  localparam int BitBadOpcode    = 20;
  localparam int BitWrRunOn      = 19;
  localparam int BitWrShort      = 18;
  localparam int BitRdRunOn      = 17;
  localparam int BitRdShort      = 16;
  localparam int BitWrSpace      = 5;
  localparam int BitRdData       = 4;
  localparam int BitAccActive    = 3;
  localparam int BitIntSummary   = 2;
  localparam int BitSerSummary   = 1;
  localparam int BitAnySummary   = 0;

  // sticky flags: index of each event in the flag vector
  localparam int NumFlags        = 12;
  localparam logic [NumFlags-1:0] FlagReset = 12'h000;

  // flag vector index -> status word bit
  localparam int FlagPos [NumFlags] = '{
    BitRdShort, BitRdRunOn, BitWrShort, BitWrRunOn, BitBadOpcode,
    BitFraming, BitWrOverflow, BitRdEmpty, BitRdUnderflow,
    BitErrLogEntry, BitIntWriteErr, BitIntReadErr};

  // flags 0..5 are serial protocol errors, 6..11 internal access errors
  localparam int NumSerFlags     = 6;

  localparam int QueueCountWidth = 8;
  localparam int BitCountWidth   = 3;
  localparam logic [31:0] StatusReset = 32'h0000_0000;

endpackage

// [w1c_flag.sv]
`timescale 1ns/1ps
module w1c_flag (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // event and clear
  input  wire logic setPulse,
  input  wire logic clearPulse,
  // state
  output logic      flag
);

  logic next_flag;

  always_comb begin
    next_flag = flag;
    if (clearPulse) begin
      next_flag = 1'b0;
    end
    if (setPulse) begin
      next_flag = 1'b1; // RULE_19
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule // w1c_flag

// [frame_bit_counter.sv]
`timescale 1ns/1ps
module frame_bit_counter (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // synchronised serial framing
  input  wire logic selActive,
  input  wire logic bitStrobe,
  // result
  output logic      framingFault
);

  logic [spi_status_pkg::BitCountWidth-1:0] bitCount;
  logic [spi_status_pkg::BitCountWidth-1:0] next_bitCount;
  logic                                     selPrev;
  logic                                     next_framingFault;

  always_comb begin
    next_bitCount     = bitCount;
    next_framingFault = 1'b0;
    if (selActive && bitStrobe) begin
      next_bitCount = bitCount + 3'h1;
    end
    if (selPrev && !selActive) begin
      next_framingFault = (bitCount != 3'h0); // RULE_07
      next_bitCount     = 3'h0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bitCount     <= 3'h0;
      selPrev      <= 1'b0;
      framingFault <= 1'b0;
    end else begin
      bitCount     <= next_bitCount;
      selPrev      <= selActive;
      framingFault <= next_framingFault;
    end
  end

endmodule // frame_bit_counter

// [spi_host_interface_status.sv]
// Contract
// RULE_01: internal read error sets read fail flag; reset 0, write 1 clears.
// RULE_02: internal write error sets write fail flag; reset 0, write 1 clears
// RULE_03: new error log entry sets log flag; reset 0, write 1 clears.
// RULE_04: read queue dry after first word sets underflow; write 1 clears.
// RULE_05: no data for first read word sets empty flag; write one clears.
// RULE_06: push into full write queue sets overflow flag; write 1 clears.
// RULE_07: select release off byte boundary sets framing flag; write 1 clears
// RULE_08: unrecognised serial command sets bad opcode flag; write 1 clears.
// RULE_09: write sequence requesting past its length sets write run-on flag.
// RULE_10: write sequence ending short of its length sets write short flag.
// RULE_11: read sequence requesting past its length sets read run-on flag.
// RULE_12: read sequence ending short of its length sets read short flag.
// RULE_13: write space bit high while free entries reach write threshold.
// RULE_14: access active bit high during internal multiple-transfer access.
// RULE_15: serial summary bit high when any unmasked serial error flag set.
// RULE_16: reserved bits read zero and ignore writes.
// RULE_17: read data bit high while read entries reach read threshold.
// RULE_18: internal summary bit high when any unmasked internal flag set.
// RULE_19: flags stay set until written 1; a same-cycle event keeps them set.
// RULE_20: host writes ones only at handled positions to avoid losing events.
`timescale 1ns/1ps
module spi_host_interface_status (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // serial framing pins (asynchronous)
  input  wire logic        chipSelN,
  input  wire logic        serialClk,
  // serial protocol events
  input  wire logic        badOpcode,
  input  wire logic        wrRunOn,
  input  wire logic        wrShort,
  input  wire logic        rdRunOn,
  input  wire logic        rdShort,
  // internal access events
  input  wire logic        intReadErr,
  input  wire logic        intWriteErr,
  input  wire logic        errLogEntry,
  input  wire logic        rdQueuePop,
  input  wire logic        rdFirstWord,
  input  wire logic        rdQueueEmpty,
  input  wire logic        wrQueuePush,
  input  wire logic        wrQueueFull,
  input  wire logic        multiAccess,
  // queue levels and thresholds
  input  wire logic [7:0]  wrFreeCount,
  input  wire logic [7:0]  wrThreshold,
  input  wire logic [7:0]  rdCount,
  input  wire logic [7:0]  rdThreshold,
  input  wire logic [11:0] flagMask,
  // status register port
  input  wire logic        statusWrite,
  input  wire logic [31:0] statusWdata,
  output logic      [31:0] statusRdata,
  // summary interrupt outputs
  output logic             serErrIrq,
  output logic             intErrIrq
);

  localparam int NF = spi_status_pkg::NumFlags;
  localparam int NS = spi_status_pkg::NumSerFlags;

  logic [2:0]    csSync;
  logic [2:0]    sckSync;
  logic          sckRise;
  logic          framingFault;
  logic [NF-1:0] setVec;
  logic [NF-1:0] clrVec;
  logic [NF-1:0] flags;
  logic [NF-1:0] unmasked;
  logic [31:0]   next_statusRdata;
  logic          next_serErrIrq;
  logic          next_intErrIrq;

  // pin synchronisers; stage 0 read only by stage 1
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      csSync  <= 3'h7;
      sckSync <= 3'h0;
    end else begin
      csSync  <= {csSync[1:0], chipSelN};
      sckSync <= {sckSync[1:0], serialClk};
    end
  end

  assign sckRise = sckSync[1] && !sckSync[2];

  frame_bit_counter u_frame (
    .clock        (clock),
    .rst          (rst),
    .selActive    (!csSync[1]),
    .bitStrobe    (sckRise),
    .framingFault (framingFault)
  );

  always_comb begin
    setVec     = '0;
    setVec[0]  = rdShort;                                 // RULE_12
    setVec[1]  = rdRunOn;                                 // RULE_11
    setVec[2]  = wrShort;                                 // RULE_10
    setVec[3]  = wrRunOn;                                 // RULE_09
    setVec[4]  = badOpcode;                               // RULE_08
    setVec[5]  = framingFault;                            // RULE_07
    setVec[6]  = wrQueuePush && wrQueueFull;              // RULE_06
    setVec[7]  = rdQueuePop && rdFirstWord && rdQueueEmpty; // RULE_05
    setVec[8]  = rdQueuePop && !rdFirstWord && rdQueueEmpty; // RULE_04
    setVec[9]  = errLogEntry;                             // RULE_03
    setVec[10] = intWriteErr;                             // RULE_02
    setVec[11] = intReadErr;                              // RULE_01
  end

  // one sticky flag per event, cleared by writing one at its position
  generate
    for (genvar i = 0; i < NF; i++) begin : g_flag
      assign clrVec[i] =
        statusWrite && statusWdata[spi_status_pkg::FlagPos[i]];
      w1c_flag u_flag (
        .clock      (clock),
        .rst        (rst),
        .setPulse   (setVec[i]),
        .clearPulse (clrVec[i]),
        .flag       (flags[i])
      );
    end
  endgenerate

  assign unmasked = flags & ~flagMask;

  always_comb begin
    next_statusRdata = spi_status_pkg::StatusReset; // RULE_16
    for (int i = 0; i < NF; i++) begin
      next_statusRdata[spi_status_pkg::FlagPos[i]] = flags[i];
    end
    next_serErrIrq = |unmasked[NS-1:0];               // RULE_15
    next_intErrIrq = |unmasked[NF-1:NS];              // RULE_18
    next_statusRdata[spi_status_pkg::BitWrSpace] =
      (wrFreeCount >= wrThreshold);                   // RULE_13
    next_statusRdata[spi_status_pkg::BitRdData] =
      (rdCount >= rdThreshold);                       // RULE_17
    next_statusRdata[spi_status_pkg::BitAccActive] = multiAccess; // RULE_14
    next_statusRdata[spi_status_pkg::BitIntSummary] = next_intErrIrq;
    next_statusRdata[spi_status_pkg::BitSerSummary] = next_serErrIrq;
    next_statusRdata[spi_status_pkg::BitAnySummary] =
      next_intErrIrq || next_serErrIrq;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      statusRdata <= spi_status_pkg::StatusReset;
      serErrIrq   <= 1'b0;
      intErrIrq   <= 1'b0;
    end else begin
      statusRdata <= next_statusRdata;
      serErrIrq   <= next_serErrIrq;
      intErrIrq   <= next_intErrIrq;
    end
  end

endmodule // spi_host_interface_status

// [spi_status_checker.sv]
`timescale 1ns/1ps
module spi_status_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // events and levels
  input wire logic        rdShort,
  input wire logic        rdQueuePop,
  input wire logic        rdFirstWord,
  input wire logic        rdQueueEmpty,
  input wire logic        wrQueuePush,
  input wire logic        wrQueueFull,
  input wire logic [7:0]  wrFreeCount,
  input wire logic [7:0]  wrThreshold,
  input wire logic [11:0] flagMask,
  // status port
  input wire logic        statusWrite,
  input wire logic [31:0] statusWdata,
  input wire logic [31:0] statusRdata,
  input wire logic        serErrIrq,
  input wire logic        intErrIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_short; rdShort |-> ##2 statusRdata[16]; endproperty
  a_short: assert property (p_short) else $error("short lost");
  property p_empty;
    rdQueuePop && rdQueueEmpty && rdFirstWord |-> ##2 statusRdata[25];
  endproperty
  a_empty: assert property (p_empty) else $error("empty lost");
  property p_over; wrQueuePush && wrQueueFull |-> ##2 statusRdata[24];
  endproperty
  a_over: assert property (p_over) else $error("overflow lost");
  property p_clear;
    statusWrite && statusWdata[16] && !rdShort |-> ##2 !statusRdata[16];
  endproperty
  a_clear: assert property (p_clear) else $error("not cleared");
  property p_space;
    !$past(rst) |->
      statusRdata[5] == ($past(wrFreeCount) >= $past(wrThreshold));
  endproperty
  a_space: assert property (p_space) else $error("space bit");
  property p_ser;
    !$past(rst) |-> serErrIrq ==
      |({statusRdata[29:24], statusRdata[21:16]} & ~$past(flagMask) &
        12'h03f);
  endproperty
  a_ser: assert property (p_ser) else $error("serial summary");
  property p_int;
    !$past(rst) |-> intErrIrq ==
      |({statusRdata[29:24], statusRdata[21:16]} & ~$past(flagMask) &
        12'hfc0);
  endproperty
  a_int: assert property (p_int) else $error("internal summary");
  property p_unused_bits;
    {statusRdata[31:30], statusRdata[23:22], statusRdata[15:6]} == 14'h0;
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused bits set");
endmodule // spi_status_checker
bind spi_host_interface_status spi_status_checker chk (.*);

// [host_master.sv]
`timescale 1ns/1ps
module host_master (
  // clock
  input wire logic clock,
  // serial pins
  output logic     chipSelN,
  output logic     serialClk
);
  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
  end
  // clock rests low outside frames, four cycles per bit
  task automatic frame(input int bits);
    chipSelN = 1'b0;
    repeat (2) @(negedge clock);
    for (int i = 0; i < bits; i++) begin
      serialClk = 1'b1;
      repeat (2) @(negedge clock);
      serialClk = 1'b0;
      repeat (2) @(negedge clock);
    end
    chipSelN = 1'b1;
  endtask
endmodule // host_master

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %0t %h %h", $time, a, e); end end
module testbench;
  logic        clock, rst, qFull, qEmpty, multi, wr, csN, sck, serIrq, intIrq;
  logic [11:0] ev, mask, model;
  logic [7:0]  wrFree, wrThr, rdCnt, rdThr;
  logic [31:0] wdata, rdata;
  int          failures, checks_done;
  host_master host (.clock(clock), .chipSelN(csN), .serialClk(sck));
  spi_host_interface_status uut (.clock(clock), .rst(rst),
    .chipSelN(csN), .serialClk(sck), .badOpcode(ev[4]), .wrRunOn(ev[3]),
    .wrShort(ev[2]), .rdRunOn(ev[1]), .rdShort(ev[0]), .intReadErr(ev[11]),
    .intWriteErr(ev[10]), .errLogEntry(ev[9]), .rdQueuePop(ev[7] | ev[8]),
    .rdFirstWord(ev[7]), .rdQueueEmpty(qEmpty), .wrQueuePush(ev[6]),
    .wrQueueFull(qFull), .multiAccess(multi), .wrFreeCount(wrFree),
    .wrThreshold(wrThr), .rdCount(rdCnt), .rdThreshold(rdThr),
    .flagMask(mask), .statusWrite(wr), .statusWdata(wdata),
    .statusRdata(rdata), .serErrIrq(serIrq), .intErrIrq(intIrq));
  function automatic logic [31:0] expWord();
    logic [31:0] w;
    logic        s;
    logic        n;
    w = 32'h0;
    for (int i = 0; i < 12; i++) w[spi_status_pkg::FlagPos[i]] = model[i];
    s = |(model[5:0] & ~mask[5:0]);
    n = |(model[11:6] & ~mask[11:6]);
    w[5:0] = {wrFree >= wrThr, rdCnt >= rdThr, multi, n, s, s | n};
    return w;
  endfunction
  task automatic check();
    logic [31:0] w;
    w = expWord();
    `CHK({rdata, serIrq, intIrq}, {w, w[1], w[2]})
  endtask
  task automatic hostWrite(input logic [31:0] d);
    wr = 1'b1;
    wdata = d;
    @(negedge clock);
    wr = 1'b0;
    @(negedge clock);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    stop_test();
  end
  initial begin
    {rst, qFull, qEmpty, multi, wr, ev, mask, model} = {5'h1c, 36'h0};
    {wrFree, wrThr, rdCnt, rdThr, wdata} = 64'h0;
    failures = 0;
    checks_done = 0;
    void'($urandom(54));
    repeat (10) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check();
    for (int i = 0; i < 12; i++) begin
      if (i == 5) continue;
      {wrFree, wrThr, rdCnt, rdThr} = $urandom;
      {multi, mask} = 13'($urandom);
      if (i == 0) wrThr = wrFree;
      if (i == 1) rdThr = rdCnt;
      ev[i] = 1'b1;
      @(negedge clock);
      ev = 12'h000;
      @(negedge clock);
      model[i] = 1'b1;
      check();
      // event coincides with clear
      ev[i] = 1'b1;
      hostWrite(32'h1 << spi_status_pkg::FlagPos[i]);
      ev = 12'h000;
      check();
      hostWrite((32'h1 << spi_status_pkg::FlagPos[i]) | 32'hc0c0_ffff);
      model[i] = 1'b0;
      check();
    end
    ev = 12'($urandom) & 12'hedf;
    model = ev;
    @(negedge clock);
    ev = 12'h000;
    @(negedge clock);
    check();
    hostWrite(expWord() & 32'h00ff_0000);
    model[5:0] = 6'h00;
    check();
    hostWrite(32'h3f00_0000);
    {qFull, qEmpty, model, ev} = {2'b00, 12'h000, 12'h1c0};
    @(negedge clock);
    ev = 12'h000;
    @(negedge clock);
    check();
    host.frame(5);
    repeat (8) @(negedge clock);
    model[5] = 1'b1;
    check();
    hostWrite(32'h0020_0000);
    model[5] = 1'b0;
    host.frame(16);
    repeat (8) @(negedge clock);
    check();
    // flags set, then a mid-run reset must clear them all
    ev = 12'he1f;
    model = 12'he1f;
    @(negedge clock);
    ev = 12'h000;
    @(negedge clock);
    check();
    rst = 1'b1;
    @(negedge clock);
    `CHK({rdata, serIrq, intIrq}, 34'h0)
    rst = 1'b0;
    model = 12'h000;
    @(negedge clock);
    check();
    stop_test();
  end
endmodule // testbench
